// >>> inc/area_decoder_pkg.sv
// constants, register map and wait-code decoding for the chip-select area decoder
// Functional notes
// RL1: four areas plus default, own width/waits
// RL2: pin drives select only when function bit set
// RL3: compare address each cycle, apply area settings
// RL4: start register gives A23..A16, rest zero
// RL5: mask bit one excludes address bit from compare
// RL6: area 0 mask covers A20..A8
// RL7: area 1 mask covers A21..A8
// RL8: areas 2, 3 mask cover A22..A15
// RL9: start and mask registers reset to all ones
// RL10: after reset only area 2, whole space
// RL11: unmatched addresses use default-region settings
// RL12: overlap or whole space: lowest area wins
// RL13: software aligns start to area size
// RL14: external wait request extends bus cycles
// RL15: three-bit wait code table, 100 reserved
// RL16: bit 3 selects 16-bit or 8-bit bus
// RL17: bit 7 enables area decoding
// RL18: select held low through whole cycle
package area_decoder_pkg;
    localparam int NUM_AREAS = 4;
    localparam int ADDR_W = 24;
    localparam int START_LOW_W = 16;
    localparam int WB_ADR_W = 10;

    // ****************************************
    // register indices, byte address is four times the index
    // ****************************************
    localparam logic [7:0] IDX_START [NUM_AREAS] = '{8'hC8, 8'hCA, 8'hCC, 8'hCE};
    localparam logic [7:0] IDX_MASK [NUM_AREAS] = '{8'hC9, 8'hCB, 8'hCD, 8'hCF};
    localparam logic [7:0] IDX_CTRL [NUM_AREAS] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3};
    localparam logic [7:0] IDX_DEFAULT_CTRL = 8'hC7;
    localparam logic [7:0] IDX_PORT6_FUNC = 8'hD0;
    localparam logic [7:0] IDX_STATUS = 8'hD1;
    localparam logic [7:0] IDX_PORT6_DATA = 8'hD2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] START_RST = 8'hFF;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] CTRL_RST [NUM_AREAS] = '{8'h00, 8'h00, 8'h80, 8'h00};
    localparam logic [3:0] DEFAULT_CTRL_RST = 4'h0;
    localparam logic [3:0] PORT6_FUNC_RST = 4'h0;
    localparam logic [3:0] PORT6_DATA_RST = 4'hF;

    // ****************************************
    // control fields
    // ****************************************
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_WHOLE_BIT = 6;
    localparam int CTRL_WIDTH_BIT = 3;
    localparam int WHOLE_AREA = 2;

    // internal resources that whole-space mode leaves out
    localparam logic [23:0] INTERNAL_IO_LAST = 24'h000FDF;
    localparam logic [23:0] INTERNAL_RAM_FIRST = 24'h001000;
    localparam logic [23:0] INTERNAL_RAM_LAST = 24'h002FFF;

    // ****************************************
    // wait codes
    // ****************************************
    localparam logic [2:0] WAIT_TWO = 3'h0;
    localparam logic [2:0] WAIT_ONE = 3'h1;
    localparam logic [2:0] WAIT_ONE_EXT = 3'h2;
    localparam logic [2:0] WAIT_ZERO = 3'h3;
    localparam logic [2:0] WAIT_RSVD = 3'h4;
    localparam logic [2:0] WAIT_THREE = 3'h5;
    localparam logic [2:0] WAIT_FOUR = 3'h6;
    localparam logic [2:0] WAIT_EIGHT = 3'h7;

    // RL15 wait code table
    function automatic logic [3:0] wait_count(input logic [2:0] code);
        case (code)
            WAIT_ONE, WAIT_ONE_EXT: wait_count = 4'h1;
            WAIT_ZERO: wait_count = 4'h0;
            WAIT_THREE: wait_count = 4'h3;
            WAIT_FOUR: wait_count = 4'h4;
            WAIT_EIGHT: wait_count = 4'h8;
            default: wait_count = 4'h2; // reserved code behaves as two waits
        endcase
    endfunction

    // lowest-numbered set bit, picks the area control settings latched at cycle start
    function automatic logic [1:0] first_index(input logic [3:0] hits);
        if (hits[0]) begin
            first_index = 2'h0;
        end else if (hits[1]) begin
            first_index = 2'h1;
        end else if (hits[2]) begin
            first_index = 2'h2;
        end else begin
            first_index = 2'h3;
        end
    endfunction
endpackage

// >>> inc/wait_seq_if.sv
// handshake between bus-cycle control and the wait-state sequencer
`timescale 1ns/1ps
`default_nettype none
interface wait_seq_if;
    logic start;
    logic [2:0] wait_code;
    logic ext_wait_n;
    logic done;
    logic busy;
    modport ctl (output start, output wait_code, output ext_wait_n, input done, input busy);
    modport seq (input start, input wait_code, input ext_wait_n, output done, output busy);
endinterface
`default_nettype wire

// >>> rtl/area_match.sv
// address compare for one chip-select area
`timescale 1ns/1ps
`default_nettype none
module area_match import area_decoder_pkg::*; #(
    parameter int AREA = 0
) (
    input wire logic [23:0] addr_i,
    input wire logic [7:0] start_i,
    input wire logic [7:0] mask_i,
    input wire logic enable_i,
    input wire logic whole_space_i,
    output logic hit_o
);
    // ones mark address bits left out of the compare
    function automatic logic [23:0] ignore_bits(input logic [7:0] m);
        logic [23:0] ign;
        ign = 24'h000000;
        if (AREA == 0) begin
            // RL6 area 0 mask layout
            ign[20:15] = m[7:2];
            ign[14:9] = {6{m[1]}};
            ign[8] = m[0];
            ign[7:0] = 8'hFF;
        end else if (AREA == 1) begin
            // RL7 area 1 mask layout
            ign[21:16] = m[7:2];
            ign[15:9] = {7{m[1]}};
            ign[8] = m[0];
            ign[7:0] = 8'hFF;
        end else begin
            // RL8 areas 2, 3 layout
            ign[22:15] = m;
            ign[14:0] = 15'h7FFF;
        end
        ignore_bits = ign;
    endfunction

    // RL4 start on 64K boundary
    wire [23:0] start_full = {start_i, {START_LOW_W{1'b0}}};
    // RL5 masked bits ignored
    wire range_hit = ((addr_i ^ start_full) & ~ignore_bits(mask_i)) == 24'h000000;
    wire in_internal = (addr_i <= INTERNAL_IO_LAST) ||
        ((addr_i >= INTERNAL_RAM_FIRST) && (addr_i <= INTERNAL_RAM_LAST));
    // RL17 master enable gates decode
    assign hit_o = enable_i && (whole_space_i ? !in_internal : range_hit);
endmodule
`default_nettype wire

// >>> rtl/wait_sequencer.sv
// counts wait states of one bus cycle and honours the external wait request
`timescale 1ns/1ps
`default_nettype none
module wait_sequencer import area_decoder_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    wait_seq_if.seq sq
);
    typedef enum {SEQ_IDLE, SEQ_COUNT, SEQ_EXT} seq_state_e;
    seq_state_e state_q;
    logic [3:0] cnt_q;
    logic ext_q;
    logic done_q;

    wire cnt_zero = cnt_q == 4'h0;
    assign sq.done = done_q;
    assign sq.busy = state_q != SEQ_IDLE;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            state_q <= SEQ_IDLE;
            cnt_q <= 4'h0;
            ext_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            case (state_q)
                SEQ_IDLE: begin
                    if (sq.start) begin
                        // RL15 load wait count
                        cnt_q <= wait_count(sq.wait_code);
                        ext_q <= sq.wait_code == WAIT_ONE_EXT;
                        state_q <= SEQ_COUNT;
                    end
                end
                SEQ_COUNT: begin
                    if (!cnt_zero) begin
                        cnt_q <= cnt_q - 4'h1;
                    end else if (ext_q && !sq.ext_wait_n) begin
                        // RL14 external wait extends
                        state_q <= SEQ_EXT;
                    end else begin
                        done_q <= 1'b1;
                        state_q <= SEQ_IDLE;
                    end
                end
                SEQ_EXT: begin
                    if (sq.ext_wait_n) begin
                        done_q <= 1'b1;
                        state_q <= SEQ_IDLE;
                    end
                end
                default: state_q <= SEQ_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> rtl/chip_select_area_decoder.sv
// chip-select area decoder: register file, area decode and bus-cycle control
//
// Implementation choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module chip_select_area_decoder import area_decoder_pkg::*; (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic bus_req_i,
    input wire logic [23:0] bus_addr_i,
    input wire logic ext_wait_n_i,
    output logic area0_select_n_o,
    output logic area1_select_n_o,
    output logic area2_select_n_o,
    output logic area3_select_n_o,
    output logic bus_width8_o,
    output logic bus_busy_o,
    output logic bus_done_o
);
    // ****************************************
    // register bus
    // ****************************************
    logic ack_q;
    logic [31:0] dat_q;
    logic [7:0] start_q [NUM_AREAS];
    logic [7:0] mask_q [NUM_AREAS];
    logic [7:0] ctrl_q [NUM_AREAS];
    logic [3:0] default_ctrl_q;
    logic [3:0] port6_func_q;
    logic [3:0] port6_data_q;

    wire [7:0] reg_idx = wb_adr_i[9:2];
    wire bus_req = wb_cyc_i && wb_stb_i;
    // write lands on the edge where the master sees ack
    wire wr_en = bus_req && wb_we_i && ack_q && wb_sel_i[0];
    wire rd_take = bus_req && !ack_q;
    wire [7:0] wr_byte = wb_dat_i[7:0];

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= rd_take;
        end
    end

    // RL9 start and mask reset
    // RL10 only area 2 after reset
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < NUM_AREAS; i++) begin
                start_q[i] <= START_RST;
                mask_q[i] <= MASK_RST;
                ctrl_q[i] <= CTRL_RST[i];
            end
        end else if (wr_en) begin
            for (int i = 0; i < NUM_AREAS; i++) begin
                if (reg_idx == IDX_START[i]) begin
                    start_q[i] <= wr_byte;
                end
                if (reg_idx == IDX_MASK[i]) begin
                    mask_q[i] <= wr_byte;
                end
                if (reg_idx == IDX_CTRL[i]) begin
                    ctrl_q[i] <= wr_byte;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            default_ctrl_q <= DEFAULT_CTRL_RST;
            port6_func_q <= PORT6_FUNC_RST;
            port6_data_q <= PORT6_DATA_RST;
        end else if (wr_en) begin
            if (reg_idx == IDX_DEFAULT_CTRL) begin
                default_ctrl_q <= wr_byte[3:0];
            end
            if (reg_idx == IDX_PORT6_FUNC) begin
                port6_func_q <= wr_byte[3:0];
            end
            if (reg_idx == IDX_PORT6_DATA) begin
                port6_data_q <= wr_byte[3:0];
            end
        end
    end

    // ****************************************
    // read selection
    // ****************************************
    logic [7:0] status_byte;
    wire [7:0] area_rd [NUM_AREAS];
    wire [7:0] area_rd_or [NUM_AREAS+1];
    assign area_rd_or[0] = 8'h00;

    genvar g;
    generate
        for (g = 0; g < NUM_AREAS; g++) begin : g_rd
            assign area_rd[g] = ({8{reg_idx == IDX_START[g]}} & start_q[g]) |
                ({8{reg_idx == IDX_MASK[g]}} & mask_q[g]) |
                ({8{reg_idx == IDX_CTRL[g]}} & ctrl_q[g]);
            assign area_rd_or[g+1] = area_rd_or[g] | area_rd[g];
        end
    endgenerate

    // unmapped indices read as zero
    wire [7:0] rd_byte = area_rd_or[NUM_AREAS] |
        ({8{reg_idx == IDX_DEFAULT_CTRL}} & {4'h0, default_ctrl_q}) |
        ({8{reg_idx == IDX_PORT6_FUNC}} & {4'h0, port6_func_q}) |
        ({8{reg_idx == IDX_PORT6_DATA}} & {4'h0, port6_data_q}) |
        ({8{reg_idx == IDX_STATUS}} & status_byte);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            dat_q <= 32'h00000000;
        end else if (rd_take) begin
            dat_q <= {24'h000000, rd_byte};
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // ****************************************
    // area decode
    // ****************************************
    logic [NUM_AREAS-1:0] hits;
    logic [NUM_AREAS-1:0] win;

    generate
        for (g = 0; g < NUM_AREAS; g++) begin : g_area
            // RL3 per-area address compare
            area_match #(.AREA(g)) u_match (
                .addr_i(bus_addr_i),
                .start_i(start_q[g]),
                .mask_i(mask_q[g]),
                .enable_i(ctrl_q[g][CTRL_EN_BIT]),
                .whole_space_i((g == WHOLE_AREA) && !ctrl_q[g][CTRL_WHOLE_BIT]),
                .hit_o(hits[g])
            );
            // RL12 lowest area wins
            if (g == 0) begin : g_first
                assign win[g] = hits[g];
            end else begin : g_rest
                assign win[g] = hits[g] && !(|hits[g-1:0]);
            end
        end
    endgenerate

    wire any_hit = |hits;
    wire [1:0] win_idx = first_index(hits);
    // RL1 per-region settings
    // RL11 default region when unmatched
    wire [3:0] region_ctrl = any_hit ? ctrl_q[win_idx][3:0] : default_ctrl_q;

    // ****************************************
    // bus cycle control
    // ****************************************
    wait_seq_if sq ();
    logic seq_start_q;
    logic [2:0] code_q;
    logic active_q;
    logic width8_q;
    logic done_q;
    logic default_used_q;
    logic [NUM_AREAS-1:0] sel_n_q;
    logic [NUM_AREAS-1:0] last_win_q;
    logic [NUM_AREAS-1:0] pin_q;

    // new cycles are refused while one is running
    wire cycle_start = bus_req_i && !active_q;

    wait_sequencer u_seq (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .sq(sq.seq)
    );

    assign sq.start = seq_start_q;
    assign sq.wait_code = code_q;
    // RL14 external wait request
    assign sq.ext_wait_n = ext_wait_n_i;

    // RL18 select held through waits
    wire [NUM_AREAS-1:0] sel_n_d = cycle_start ? ~win :
        (sq.done ? {NUM_AREAS{1'b1}} : sel_n_q);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            seq_start_q <= 1'b0;
            code_q <= WAIT_TWO;
            active_q <= 1'b0;
            width8_q <= 1'b0;
            done_q <= 1'b0;
            default_used_q <= 1'b0;
            sel_n_q <= {NUM_AREAS{1'b1}};
            last_win_q <= {NUM_AREAS{1'b0}};
        end else begin
            seq_start_q <= cycle_start;
            done_q <= sq.done;
            sel_n_q <= sel_n_d;
            if (cycle_start) begin
                active_q <= 1'b1;
                code_q <= region_ctrl[2:0];
                // RL16 width bit, one means 8-bit
                width8_q <= region_ctrl[CTRL_WIDTH_BIT];
                last_win_q <= win;
                default_used_q <= !any_hit;
            end else if (sq.done) begin
                active_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // port 6 pins
    // ****************************************
    // pins follow the next select value so they change with the cycle, not a clock later
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            pin_q <= PORT6_DATA_RST;
        end else begin
            for (int i = 0; i < NUM_AREAS; i++) begin
                // RL2 function bit picks select
                pin_q[i] <= port6_func_q[i] ? sel_n_d[i] : port6_data_q[i];
            end
        end
    end

    assign area0_select_n_o = pin_q[0];
    assign area1_select_n_o = pin_q[1];
    assign area2_select_n_o = pin_q[2];
    assign area3_select_n_o = pin_q[3];
    assign bus_width8_o = width8_q;
    assign bus_busy_o = active_q;
    assign bus_done_o = done_q;

    // status: last winner, default use, activity, width
    assign status_byte = {1'b0, width8_q, active_q, default_used_q, last_win_q};
endmodule
`default_nettype wire

// >>> testbench/csad_assertions.sv
// concurrent checks on the chip-select area decoder pins
`timescale 1ns/1ps
`default_nettype none
module csad_assertions (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic bus_req_i,
    input wire logic ext_wait_n_i,
    input wire logic area0_select_n_o,
    input wire logic area1_select_n_o,
    input wire logic area2_select_n_o,
    input wire logic area3_select_n_o,
    input wire logic bus_width8_o,
    input wire logic bus_busy_o,
    input wire logic bus_done_o
);
    wire logic [3:0] sel_n;
    assign sel_n = {area3_select_n_o, area2_select_n_o, area1_select_n_o, area0_select_n_o};
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);

    // ****************************************
    // properties
    // ****************************************
    property p_one_sel;
        $onehot0(~sel_n);
    endproperty
    a_one_sel: assert property (p_one_sel) else $error("more than one select low");
    property p_sel_busy;
        !(&sel_n) |-> bus_busy_o;
    endproperty
    a_sel_busy: assert property (p_sel_busy) else $error("select low outside a cycle");
    property p_sel_hold;
        bus_busy_o && $past(bus_busy_o) |-> $stable(sel_n);
    endproperty
    a_sel_hold: assert property (p_sel_hold) else $error("select moved mid cycle");
    property p_take;
        bus_req_i && !bus_busy_o |=> bus_busy_o;
    endproperty
    a_take: assert property (p_take) else $error("request not taken");
    property p_no_early_done;
        $rose(bus_busy_o) |-> !bus_done_o ##1 !bus_done_o;
    endproperty
    a_no_early_done: assert property (p_no_early_done) else $error("cycle ended early");
    property p_done_bound;
        $rose(bus_busy_o) |-> ##[2:20] bus_done_o;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("cycle never ended");
    property p_done_end;
        bus_done_o |-> !bus_busy_o && (&sel_n);
    endproperty
    a_done_end: assert property (p_done_end) else $error("select kept after end");
    property p_done_pulse;
        bus_done_o |=> !bus_done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than a cycle");
    property p_width_hold;
        bus_busy_o && $past(bus_busy_o) |-> $stable(bus_width8_o);
    endproperty
    a_width_hold: assert property (p_width_hold) else $error("width moved mid cycle");
    c_area0: cover property (!area0_select_n_o);
    c_default: cover property (bus_done_o && $past(&sel_n));
    c_ext: cover property (!ext_wait_n_i && bus_busy_o);
endmodule
`default_nettype wire

// >>> testbench/ext_mem_model.sv
// far-side memory that can stretch a selected cycle with its wait request
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model #(
    parameter int HOLD = 3
) (
    input wire logic ref_clk_i,
    input wire logic [3:0] select_n_i,
    input wire logic slow_i,
    output logic wait_n_o
);
    logic [3:0] cnt_q = 4'h0;
    // counts cycles since a select went low, saturating
    always_ff @(posedge ref_clk_i) begin
        if (&select_n_i) begin
            cnt_q <= 4'h0;
        end else if (cnt_q != 4'hF) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // slow answer holds wait
    // combinational from the pin, so the request is seen in the first selected cycle
    assign wait_n_o = !(slow_i && !(&select_n_i) && (cnt_q < 4'(HOLD)));
endmodule
`default_nettype wire

// >>> testbench/chip_select_area_decoder_tb_top.sv
// self-checking bench for the chip-select area decoder
`timescale 1ns/1ps
`default_nettype none
module chip_select_area_decoder_tb_top;
    import area_decoder_pkg::*;
    typedef struct {logic [3:0] sel; logic w8; int lo; int hi;} cyc_exp_s;
    logic ref_clk, rstn, wb_cyc, wb_stb, wb_we, bus_req, slow;
    logic [9:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat;
    logic [23:0] bus_addr;
    wire logic [31:0] wb_rdat;
    wire logic wb_ack, ext_wait_n, w8, busy, done;
    wire logic [3:0] sel_n;
    int fail_count, checks, cnt, n;
    bit run;
    logic [31:0] rd_q[$];
    cyc_exp_s cyc_q[$];
    cyc_exp_s m;
    int waits[8] = '{2, 1, 1, 0, 2, 3, 4, 8};
    logic [7:0] s;

    chip_select_area_decoder i_chip_select_area_decoder (.ref_clk_i(ref_clk), .rstn_i(rstn),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack),
        .bus_req_i(bus_req), .bus_addr_i(bus_addr), .ext_wait_n_i(ext_wait_n),
        .area0_select_n_o(sel_n[0]), .area1_select_n_o(sel_n[1]),
        .area2_select_n_o(sel_n[2]), .area3_select_n_o(sel_n[3]),
        .bus_width8_o(w8), .bus_busy_o(busy), .bus_done_o(done));
    ext_mem_model i_ext_mem_model (.ref_clk_i(ref_clk), .select_n_i(sel_n), .slow_i(slow),
        .wait_n_o(ext_wait_n));

    // ****************************************
    // tasks
    // ****************************************
    task automatic print_verdict;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        chk(32'h0, 32'h1);
        print_verdict();
    endtask
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
        int k;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'hF;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h000000, d};
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack !== 1'b1 && k < 20);
        if (k >= 20) timeout();
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        rd_q.push_back({24'h000000, exp});
        wb(1'b0, idx, 8'h00);
    endtask
    // back-to-back: the next request goes out at the edge that shows done
    task automatic cyc(input logic [23:0] a, input logic [3:0] sl, input logic w,
                       input int lo, input int hi);
        int k;
        cyc_q.push_back('{sl, w, lo, hi});
        bus_req <= 1'b1;
        bus_addr <= a;
        @(posedge ref_clk);
        bus_req <= 1'b0;
        bus_addr <= ~a;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (done !== 1'b1 && k < 30);
        if (k >= 30) timeout();
    endtask

    // ****************************************
    // result watchers
    // ****************************************
    always @(posedge ref_clk) begin
        if (wb_ack === 1'b1 && wb_we === 1'b0 && rd_q.size() > 0) begin
            chk(wb_rdat, rd_q.pop_front());
        end
        if (run) cnt++;
        if (run && cnt == 1) begin
            chk({28'h0, sel_n}, {28'h0, m.sel});
            chk({31'h0, w8}, {31'h0, m.w8});
        end
        if (run && done === 1'b1) begin
            // done rose one edge before it is sampled here
            chk({31'h0, (cnt - 1 >= m.lo && cnt - 1 <= m.hi)}, 32'h1);
            run = 1'b0;
        end
        if (bus_req === 1'b1 && busy === 1'b0 && rstn === 1'b1 && !run && cyc_q.size() > 0) begin
            run = 1'b1;
            cnt = 0;
            m = cyc_q.pop_front();
        end
    end

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rstn = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 10'h000;
        wb_sel = 4'hF;
        wb_dat = 32'h00000000;
        bus_req = 1'b0;
        bus_addr = 24'h000000;
        slow = 1'b0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        void'($urandom(32'h1697878A));
        for (int i = 0; i < 4; i++) begin
            rd(IDX_START[i], 8'hFF);
            rd(IDX_MASK[i], 8'hFF);
            rd(IDX_CTRL[i], CTRL_RST[i]);
        end
        rd(8'h10, 8'h00);
        $display("test reset_values end");
        wb(1'b1, IDX_PORT6_FUNC, 8'h0F);
        wb(1'b1, IDX_DEFAULT_CTRL, 8'h0B);
        cyc(24'h003000, 4'b1011, 1'b0, 5, 5);
        cyc(24'h000FE0, 4'b1011, 1'b0, 5, 5);
        cyc(24'h000100, 4'hF, 1'b1, 3, 3);
        cyc(24'h001800, 4'hF, 1'b1, 3, 3);
        $display("test after_reset_map end");
        // 64K area at 010000, start aligned to size
        wb(1'b1, IDX_START[0], 8'h01);
        wb(1'b1, IDX_MASK[0], 8'h07);
        for (int c = 0; c < 8; c++) begin
            wb(1'b1, IDX_CTRL[0], 8'h88 | 8'(c));
            cyc(24'h01FFFF, 4'b1110, 1'b1, 3 + waits[c], 3 + waits[c]);
        end
        cyc(24'h010000, 4'b1110, 1'b1, 11, 11);
        cyc(24'h020000, 4'b1011, 1'b0, 5, 5);
        cyc(24'h00FFFF, 4'b1011, 1'b0, 5, 5);
        $display("test area0_waits end");
        wb(1'b1, IDX_CTRL[0], 8'h0B);
        cyc(24'h010000, 4'b1011, 1'b0, 5, 5);
        wb(1'b1, IDX_PORT6_FUNC, 8'h00);
        cyc(24'h010000, 4'hF, 1'b0, 5, 5);
        wb(1'b1, IDX_PORT6_FUNC, 8'h0F);
        $display("test enable_and_port end");
        wb(1'b1, IDX_CTRL[0], 8'h82);
        slow <= 1'b1;
        cyc(24'h018000, 4'b1110, 1'b0, 5, 8);
        slow <= 1'b0;
        rd(IDX_STATUS, 8'h01);
        $display("test ext_wait end");
        wb(1'b1, IDX_CTRL[2], 8'h00);
        wb(1'b1, IDX_CTRL[0], 8'h00);
        s = 8'($urandom);
        wb(1'b1, IDX_START[3], s);
        wb(1'b1, IDX_MASK[3], 8'h00);
        wb(1'b1, IDX_CTRL[3], 8'h83);
        for (int i = 0; i < 8; i++) begin
            n = $urandom;
            if (n[0]) begin
                cyc({s, 1'b1, 15'(n >> 1)}, 4'hF, 1'b1, 3, 3);
            end else begin
                cyc({s, 1'b0, 15'(n >> 1)}, 4'b0111, 1'b0, 3, 3);
            end
        end
        $display("test random_area3 end");
        print_verdict();
    end
endmodule

bind chip_select_area_decoder csad_assertions i_csad_assertions (.ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i), .bus_req_i(bus_req_i), .ext_wait_n_i(ext_wait_n_i),
    .area0_select_n_o(area0_select_n_o), .area1_select_n_o(area1_select_n_o),
    .area2_select_n_o(area2_select_n_o), .area3_select_n_o(area3_select_n_o),
    .bus_width8_o(bus_width8_o), .bus_busy_o(bus_busy_o), .bus_done_o(bus_done_o));
`default_nettype wire
